// >>> verilog/smig_top.sv
// management interrupt generator: event status, handler gating, routing
// assumes plain register port on sys_clk; event pins are asynchronous
`timescale 1ns/1ps
`include "smig_defines.svh"

module smig_top #(
  parameter int DEBOUNCE_CYC = `SMIG_DEBOUNCE_CYC,
  parameter int OVERRIDE_CYC = `SMIG_OVERRIDE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire smig_pkg::smig_bus_req_t bus_req,
  output logic [31:0] rd_data,
  input wire logic power_button_in_n,
  input wire logic cover_switch_in,
  input wire logic general_event_in,
  input wire logic external_mgmt_req_n,
  input wire smig_pkg::smig_bus_ev_t bus_events,
  output logic mgmt_irq_out_n,
  output logic control_irq,
  output logic resume_event,
  output logic soft_off_req,
  output logic irq
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  // reset to idle levels, else a false event follows release
  localparam logic [7:0] SYNC_RST = `SMIG_SYNC_RST;
  wire [7:0] raw_in = {bus_events, external_mgmt_req_n, general_event_in,
                       cover_switch_in, power_button_in_n};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          sync1_r[gi] <= SYNC_RST[gi];
          sync2_r[gi] <= SYNC_RST[gi];
        end else begin
          sync1_r[gi] <= raw_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [4:0] ctrl_r;
  logic [`SMIG_NEV-1:0] en_r;
  logic [`SMIG_NEV-1:0] sts_r;
  logic [`SMIG_NEV-1:0] sts_nxt;
  logic [`SMIG_NEV-1:0] ev_set;
  logic [`SMIG_NEV-1:0] mask_r;
  logic irq_sts_r;
  logic done_r;
  wire wr_ctrl = bus_req.wr && bus_req.addr == `SMIG_OFS_CTRL;
  wire wr_sts = bus_req.wr && bus_req.addr == `SMIG_OFS_STS;
  wire gen_en = ctrl_r[`SMIG_CTRL_GEN];
  wire route_ctl = ctrl_r[`SMIG_CTRL_ROUTE];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= `SMIG_CTRL_RST;
      en_r <= `SMIG_EN_RST;
      mask_r <= `SMIG_EN_RST;
    end else if (bus_req.wr) begin
      if (bus_req.addr == `SMIG_OFS_CTRL)
        ctrl_r <= bus_req.wdata[4:0];
      if (bus_req.addr == `SMIG_OFS_EN)
        en_r <= bus_req.wdata[`SMIG_NEV-1:0];
      if (bus_req.addr == `SMIG_OFS_MASK)
        mask_r <= bus_req.wdata[`SMIG_NEV-1:0];
    end
  end

  // ----------------------------------------
  // debounce filters for button and cover
  // ----------------------------------------
  logic [31:0] btn_cnt_r;
  logic [31:0] cov_cnt_r;
  logic btn_db_r;
  logic cov_db_r;
  logic cov_db_d_r;
  logic btn_db_d_r;
  logic [31:0] hold_cnt_r;
  logic ovr_fire;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      btn_cnt_r <= 32'h0;
      btn_db_r <= 1'b0;
    end else if (!sync2_r[0] == btn_db_r) begin
      btn_cnt_r <= 32'h0;
    end else if (btn_cnt_r >= 32'(DEBOUNCE_CYC - 1)) begin
      btn_cnt_r <= 32'h0;
      btn_db_r <= !sync2_r[0];
    end else begin
      btn_cnt_r <= btn_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cov_cnt_r <= 32'h0;
      cov_db_r <= 1'b0;
    end else if (sync2_r[1] == cov_db_r) begin
      cov_cnt_r <= 32'h0;
    end else if (cov_cnt_r >= 32'(DEBOUNCE_CYC - 1)) begin
      cov_cnt_r <= 32'h0;
      cov_db_r <= sync2_r[1];
    end else begin
      cov_cnt_r <= cov_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cov_db_d_r <= 1'b0;
      btn_db_d_r <= 1'b0;
    end else begin
      cov_db_d_r <= cov_db_r;
      btn_db_d_r <= btn_db_r;
    end
  end

  // long-press hold counter, counted from debounced press
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_cnt_r <= 32'h0;
    end else if (!btn_db_r) begin
      hold_cnt_r <= 32'h0;
    end else if (hold_cnt_r <= 32'(OVERRIDE_CYC)) begin
      hold_cnt_r <= hold_cnt_r + 32'h1;
    end
  end
  assign ovr_fire = ctrl_r[`SMIG_CTRL_OVREN] && hold_cnt_r == 32'(OVERRIDE_CYC);

  // ----------------------------------------
  // event detection and sticky status
  // ----------------------------------------
  // polarity picks the edge of the debounced cover level
  wire cov_edge = ctrl_r[`SMIG_CTRL_COVPOL] ? (cov_db_r && !cov_db_d_r)
                                            : (!cov_db_r && cov_db_d_r);

  always_comb begin
    ev_set = '0;
    ev_set[`SMIG_EV_BUTTON] = btn_db_r && !btn_db_d_r;
    ev_set[`SMIG_EV_OVERRIDE] = ovr_fire;
    ev_set[`SMIG_EV_COVER] = cov_edge;
    ev_set[`SMIG_EV_GENERAL] = !sync2_r[2];
    ev_set[`SMIG_EV_EXTREQ] = !sync2_r[3];
    ev_set[`SMIG_EV_ALERT] = sync2_r[7];
    ev_set[`SMIG_EV_TARGET] = sync2_r[6];
    ev_set[`SMIG_EV_SHADOW_A] = sync2_r[5];
    ev_set[`SMIG_EV_SHADOW_B] = sync2_r[4];
  end

  // write one to clear; a new event wins over the clear
  always_comb begin
    sts_nxt = sts_r;
    if (wr_sts)
      sts_nxt = sts_nxt & ~bus_req.wdata[`SMIG_NEV-1:0];
    // override clears button status and sets override
    if (ovr_fire)
      sts_nxt[`SMIG_EV_BUTTON] = 1'b0;
    // each event sets its own bit
    sts_nxt = sts_nxt | (ev_set & ~(ovr_fire ? `SMIG_NEV'(1) : `SMIG_NEV'(0)));
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      sts_r <= '0;
    else
      sts_r <= sts_nxt;
  end

  // enabled events feed the selected interrupt path
  wire [`SMIG_NEV-1:0] en_sts = sts_r & en_r;
  wire mgmt_pending = gen_en && !route_ctl && |en_sts;
  wire [`SMIG_NEV-1:0] en_new = ev_set & en_r;

  // ----------------------------------------
  // handler done flag and output
  // ----------------------------------------
  smig_pkg::smig_state_t state_r;
  logic armed_r;

  // no assertion until software set the flag once
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      armed_r <= 1'b0;
    else if (done_r)
      armed_r <= 1'b1;
  end

  // set refused while status pending; enabled event clears it while gen_en set and route select 0
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_r <= 1'b0;
    end else if (gen_en && !route_ctl && |en_new) begin
      done_r <= 1'b0;
    end else if (wr_ctrl && bus_req.wdata[`SMIG_CTRL_DONE] && !mgmt_pending) begin
      done_r <= 1'b1;
    end else if (done_r && mgmt_pending && state_r == smig_pkg::SMIG_IDLE) begin
      // flag set with status pending: clear again
      done_r <= 1'b0;
    end
  end

  // gap of at least two clocks between handler end and next assertion
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= smig_pkg::SMIG_IDLE;
      mgmt_irq_out_n <= 1'b1;
    end else begin
      case (state_r)
        smig_pkg::SMIG_IDLE: begin
          // once armed, flag clear with an enabled request drives output low
          if (armed_r && !done_r && mgmt_pending) begin
            state_r <= smig_pkg::SMIG_ASSERT;
            mgmt_irq_out_n <= 1'b0;
          end
        end
        smig_pkg::SMIG_ASSERT: begin
          // stays low; extra events add no new pulse
          if (done_r || !gen_en) begin
            // inactive for at least one clock
            state_r <= smig_pkg::SMIG_GAP;
            mgmt_irq_out_n <= 1'b1;
          end
        end
        smig_pkg::SMIG_GAP: begin
          state_r <= smig_pkg::SMIG_IDLE;
        end
        default: begin
          state_r <= smig_pkg::SMIG_IDLE;
          mgmt_irq_out_n <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // control irq, resume, soft-off
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      control_irq <= 1'b0;
      resume_event <= 1'b0;
      soft_off_req <= 1'b0;
    end else begin
      // route select 1 gives control irq
      control_irq <= route_ctl && |en_sts;
      // enabled events also wake a suspended system
      resume_event <= |en_new;
      // long press forces soft-off, held until reset
      if (ovr_fire)
        soft_off_req <= 1'b1;
    end
  end

  // ----------------------------------------
  // register read, read-to-clear interrupt status
  // ----------------------------------------
  wire [4:0] ctrl_view = {ctrl_r[4:2], done_r, ctrl_r[0]};
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 32'h0;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        `SMIG_OFS_CTRL: rd_data <= {27'h0, ctrl_view};
        `SMIG_OFS_EN: rd_data <= {23'h0, en_r};
        // group bit is OR of children, read only
        `SMIG_OFS_STS: rd_data <= {16'h0, |sts_r, 6'h0, sts_r};
        `SMIG_OFS_MASK: rd_data <= {23'h0, mask_r};
        `SMIG_OFS_IRQ: rd_data <= {31'h0, irq_sts_r};
        `SMIG_OFS_RAW: rd_data <= {24'h0, sync2_r};
        default: rd_data <= 32'h0;
      endcase
    end else begin
      rd_data <= 32'h0;
    end
  end

  // sticky output-assert event, cleared by reading; set wins
  wire irq_ev = armed_r && state_r == smig_pkg::SMIG_IDLE && !done_r && mgmt_pending;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      irq_sts_r <= 1'b0;
    else if (irq_ev)
      irq_sts_r <= 1'b1;
    else if (bus_req.rd && bus_req.addr == `SMIG_OFS_IRQ)
      irq_sts_r <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= irq_sts_r && mask_r[0];
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_gate;
    @(posedge sys_clk) disable iff (!rst_b)
    !gen_en |=> mgmt_irq_out_n || $past(mgmt_irq_out_n) == 1'b0;
  endproperty
  a_gate: assert property (p_gate) else $error("irq asserted while disabled");

  property p_assert;
    @(posedge sys_clk) disable iff (!rst_b)
    (armed_r && state_r == smig_pkg::SMIG_IDLE && !done_r && mgmt_pending) |=> !mgmt_irq_out_n;
  endproperty
  a_assert: assert property (p_assert) else $error("irq not asserted");

  property p_gap;
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(mgmt_irq_out_n) |=> mgmt_irq_out_n;
  endproperty
  a_gap: assert property (p_gap) else $error("inactive gap too short");

  property p_refuse;
    @(posedge sys_clk) disable iff (!rst_b)
    (wr_ctrl && mgmt_pending && !done_r) |=> !done_r;
  endproperty
  a_refuse: assert property (p_refuse) else $error("done flag set while pending");

  property p_route;
    @(posedge sys_clk) disable iff (!rst_b)
    (route_ctl && |en_sts) ##1 route_ctl |-> control_irq;
  endproperty
  a_route: assert property (p_route) else $error("control irq missing");

  property p_sticky;
    @(posedge sys_clk) disable iff (!rst_b)
    (|sts_r && !wr_sts && !ovr_fire) |=> |sts_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("status lost");

  property p_override;
    @(posedge sys_clk) disable iff (!rst_b)
    ovr_fire |=> sts_r[`SMIG_EV_OVERRIDE] && !sts_r[`SMIG_EV_BUTTON] && soft_off_req;
  endproperty
  a_override: assert property (p_override) else $error("override effect missing");

  property p_cover;
    @(posedge sys_clk) disable iff (!rst_b)
    cov_edge |=> sts_r[`SMIG_EV_COVER];
  endproperty
  a_cover: assert property (p_cover) else $error("cover status not set");

endmodule

// >>> verilog/smig_defines.svh
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz system clock
`ifndef SMIG_DEFINES_SVH
`define SMIG_DEFINES_SVH

// ----------------------------------------
// register offsets (word index on a 4-bit address)
// ----------------------------------------
`define SMIG_OFS_CTRL 4'h0
`define SMIG_OFS_EN 4'h1
`define SMIG_OFS_STS 4'h2
`define SMIG_OFS_MASK 4'h3
`define SMIG_OFS_IRQ 4'h4
`define SMIG_OFS_RAW 4'h5

// ----------------------------------------
// control fields
// ----------------------------------------
`define SMIG_CTRL_GEN 0
`define SMIG_CTRL_DONE 1
`define SMIG_CTRL_ROUTE 2
`define SMIG_CTRL_COVPOL 3
`define SMIG_CTRL_OVREN 4

// ----------------------------------------
// event bit positions (status and enable share layout)
// ----------------------------------------
`define SMIG_EV_BUTTON 0
`define SMIG_EV_OVERRIDE 1
`define SMIG_EV_COVER 2
`define SMIG_EV_GENERAL 3
`define SMIG_EV_EXTREQ 4
`define SMIG_EV_ALERT 5
`define SMIG_EV_TARGET 6
`define SMIG_EV_SHADOW_A 7
`define SMIG_EV_SHADOW_B 8
`define SMIG_NEV 9
`define SMIG_GROUP_BIT 15

// ----------------------------------------
// reset values
// ----------------------------------------
`define SMIG_CTRL_RST 5'h00
`define SMIG_EN_RST 9'h000
// synchroniser idle levels: active-low pins high, the rest low
`define SMIG_SYNC_RST 8'h0d

// ----------------------------------------
// timing
// ----------------------------------------
`define SMIG_CLK_MHZ 100
`define SMIG_DEBOUNCE_MS 16
`define SMIG_OVERRIDE_S 4
`define SMIG_DEBOUNCE_CYC (`SMIG_DEBOUNCE_MS * 1000 * `SMIG_CLK_MHZ)
`define SMIG_OVERRIDE_CYC (`SMIG_OVERRIDE_S * 1000000 * `SMIG_CLK_MHZ)

`endif

// >>> verilog/smig_pkg.sv
// types shared by the management interrupt generator
// assumes smig_defines.svh for field positions
package smig_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } smig_bus_req_t;

  typedef struct packed {
    logic alert;
    logic target;
    logic shadow_a;
    logic shadow_b;
  } smig_bus_ev_t;

  typedef enum logic [2:0] {
    SMIG_IDLE = 3'b001,
    SMIG_ASSERT = 3'b010,
    SMIG_GAP = 3'b100
  } smig_state_t;
endpackage

// >>> verification/smig_host_model.sv
// host-side model: counts entries into management mode
// assumes mgmt_irq_out_n is a registered active-low level on sys_clk
`timescale 1ns/1ps

module smig_host_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic mgmt_irq_out_n,
  output logic [7:0] entry_count
);
  logic irq_n_q_r;

  // ----------------------------------------
  // entry detect
  // ----------------------------------------
  // entry only after line seen high
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_n_q_r <= 1'b1;
      entry_count <= 8'h00;
    end else begin
      irq_n_q_r <= mgmt_irq_out_n;
      if (irq_n_q_r && !mgmt_irq_out_n) begin
        entry_count <= entry_count + 8'h01;
      end
    end
  end
endmodule

// >>> verification/system_mgmt_interrupt_gen_test.sv
// bench for the management interrupt generator, register-call tests
// assumes short debounce and override counts set at the instance
`timescale 1ns/1ps
`include "smig_defines.svh"

module system_mgmt_interrupt_gen_test;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  smig_pkg::smig_bus_req_t bus_req = '0;
  // button_n, cover, general_n, ext_n, alert, target, shadow a, shadow b
  logic [7:0] pin_r = 8'h0d;
  logic [31:0] rd_data;
  logic mgmt_irq_out_n;
  logic control_irq;
  logic resume_event;
  logic soft_off_req;
  logic irq;
  logic [7:0] entry_count;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;

  always #5 sys_clk = ~sys_clk;

  smig_top #(.DEBOUNCE_CYC(8), .OVERRIDE_CYC(40)) DUT (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .power_button_in_n(pin_r[0]),
    .cover_switch_in(pin_r[1]),
    .general_event_in(pin_r[2]),
    .external_mgmt_req_n(pin_r[3]),
    .bus_events({pin_r[4], pin_r[5], pin_r[6], pin_r[7]}),
    .mgmt_irq_out_n(mgmt_irq_out_n),
    .control_irq(control_irq),
    .resume_event(resume_event),
    .soft_off_req(soft_off_req),
    .irq(irq)
  );

  smig_host_model HOST (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .mgmt_irq_out_n(mgmt_irq_out_n),
    .entry_count(entry_count)
  );

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= {a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge sys_clk);
    bus_req <= {a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
    chk(rd_data & m, exp, "read");
  endtask

  // toggle a pin for n cycles; tail covers sync plus debounce
  task automatic pulse(input int idx, input int n);
    @(posedge sys_clk);
    pin_r[idx] <= ~pin_r[idx];
    repeat (n) @(posedge sys_clk);
    pin_r[idx] <= ~pin_r[idx];
    repeat (14) @(posedge sys_clk);
    #1;
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_count++;
      end_sim();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1;
    chk(mgmt_irq_out_n, 1'b1, "idle level");
    rd(`SMIG_OFS_CTRL, 32'h1f, 32'h0);
    rd(4'hf, 32'hffffffff, 32'h0);
    note("reset");
    wr(`SMIG_OFS_EN, 32'h1ff);
    wr(`SMIG_OFS_MASK, 32'h1);
    wr(`SMIG_OFS_CTRL, 32'h01);
    pulse(2, 6);
    chk(mgmt_irq_out_n, 1'b1, "not armed");
    wr(`SMIG_OFS_STS, 32'h1ff);
    wr(`SMIG_OFS_CTRL, 32'h02);
    pulse(2, 6);
    chk(mgmt_irq_out_n, 1'b1, "no global enable");
    rd(`SMIG_OFS_STS, 32'h81ff, 32'h8008);
    wr(`SMIG_OFS_STS, 32'h8000);
    rd(`SMIG_OFS_STS, 32'h81ff, 32'h8008);
    wr(`SMIG_OFS_STS, 32'h0008);
    rd(`SMIG_OFS_STS, 32'h81ff, 32'h0);
    note("status");
    wr(`SMIG_OFS_CTRL, 32'h03);
    pulse(2, 6);
    chk(mgmt_irq_out_n, 1'b0, "asserted");
    chk(control_irq, 1'b0, "not routed");
    chk(entry_count, 8'h01, "entries");
    rd(`SMIG_OFS_CTRL, 32'h2, 32'h0);
    chk(irq, 1'b1, "irq level");
    rd(`SMIG_OFS_IRQ, 32'h1, 32'h1);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(irq, 1'b0, "irq cleared");
    pulse(3, 6);
    chk(entry_count, 8'h01, "no extra entry");
    rd(`SMIG_OFS_STS, 32'h1ff, 32'h018);
    wr(`SMIG_OFS_CTRL, 32'h03);
    rd(`SMIG_OFS_CTRL, 32'h2, 32'h0);
    chk(mgmt_irq_out_n, 1'b0, "still asserted");
    wr(`SMIG_OFS_STS, 32'h1ff);
    wr(`SMIG_OFS_CTRL, 32'h03);
    rd(`SMIG_OFS_CTRL, 32'h2, 32'h2);
    chk(mgmt_irq_out_n, 1'b1, "released");
    pulse(3, 6);
    chk(entry_count, 8'h02, "second entry");
    wr(`SMIG_OFS_STS, 32'h1ff);
    wr(`SMIG_OFS_CTRL, 32'h03);
    note("handler");
    wr(`SMIG_OFS_CTRL, 32'h07);
    for (int i = 4; i < 8; i++) begin
      pulse(i, 3);
      rd(`SMIG_OFS_STS, 32'h1ff, 32'h1 << (i + 1));
      chk(control_irq, 1'b1, "control irq");
      chk(mgmt_irq_out_n, 1'b1, "routed away");
      wr(`SMIG_OFS_STS, 32'h1ff);
    end
    @(posedge sys_clk);
    pin_r[3] <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(resume_event, 1'b1, "resume");
    @(posedge sys_clk);
    pin_r[3] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(resume_event, 1'b0, "resume ends");
    chk(mgmt_irq_out_n, 1'b1, "pending but routed");
    wr(`SMIG_OFS_CTRL, 32'h01);
    rd(`SMIG_OFS_CTRL, 32'h2, 32'h0);
    chk(mgmt_irq_out_n, 1'b0, "re-asserted");
    repeat (2) @(posedge sys_clk);
    #1;
    chk(entry_count, 8'h03, "third entry");
    wr(`SMIG_OFS_STS, 32'h1ff);
    wr(`SMIG_OFS_CTRL, 32'h03);
    note("route");
    wr(`SMIG_OFS_CTRL, 32'h08);
    pulse(1, 3);
    rd(`SMIG_OFS_STS, 32'h4, 32'h0);
    pulse(1, 20);
    rd(`SMIG_OFS_STS, 32'h4, 32'h4);
    wr(`SMIG_OFS_STS, 32'h1ff);
    wr(`SMIG_OFS_CTRL, 32'h00);
    pulse(1, 20);
    rd(`SMIG_OFS_STS, 32'h4, 32'h4);
    wr(`SMIG_OFS_STS, 32'h1ff);
    note("cover");
    pulse(0, 4);
    rd(`SMIG_OFS_STS, 32'h1, 32'h0);
    pulse(0, 20);
    rd(`SMIG_OFS_STS, 32'h1, 32'h1);
    wr(`SMIG_OFS_STS, 32'h1ff);
    wr(`SMIG_OFS_CTRL, 32'h10);
    pulse(0, 70);
    rd(`SMIG_OFS_STS, 32'h3, 32'h2);
    chk(soft_off_req, 1'b1, "soft off");
    note("button");
    end_sim();
  end
endmodule
